// >>> tb_usb_interrupt_enable_and_error_status.sv
`timescale 1ns/1ps
`include "uiees_regs.svh"

module tb_usb_interrupt_enable_and_error_status;
	logic                       pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic                       usb_irq, error_summary_flag, last_slverr;
	logic [`UIEES_ADDR_W-1:0]   paddr;
	logic [31:0]                pwdata, prdata;
	logic [3:0]                 pstrb;
	uiees_pkg::uiees_stat_evt_t stat_evt;
	uiees_pkg::uiees_err_evt_t  err_evt;
	uiees_pkg::uiees_link_t     link;
	int                         errors, samples_checked, cycles;

	// short bit time keeps the turnaround wait at 34 cycles
	uiees_top #(.BIT_CYCLES(2), .TURN_BITS(16)) uiees_top_i (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.stat_evt(stat_evt), .err_evt(err_evt), .link(link), .usb_irq(usb_irq),
		.error_summary_flag(error_summary_flag));
	uiees_engine_model uiees_engine_model_i (.pclk(pclk), .stat_evt(stat_evt), .err_evt(err_evt),
		.link(link));

	always #2 pclk = ~pclk;
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 8000) begin
			errors++;
			end_sim();
		end
	end

	task end_sim();
		$display("errors %0d samples_checked %0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	// request held until pready is sampled high; no fixed latency assumed
	task apb(input logic w, input logic [11:0] a, input logic [7:0] d, output logic [31:0] r);
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'b1;
		// only the bench timeout may end this wait
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		r = prdata;
		last_slverr = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input logic [11:0] a, input logic [7:0] d);
		logic [31:0] r;
		apb(1'b1, a, d, r);
	endtask
	task rd(input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] r;
		apb(1'b0, a, 8'h00, r);
		chk(r, exp);
	endtask

	task t_reset_and_enables();
		rd(12'h000, 32'h00);
		rd(12'h008, 32'h00);
		rd(12'h00c, 32'h00);
		rd(12'h010, 32'h00);
		chk(last_slverr, 1'b1);
		wr(12'h000, 8'hff);
		rd(12'h000, 32'h7f);
		wr(12'h00c, 8'hff);
		rd(12'h00c, 32'h9f);
		wr(12'h004, 8'hff);
		chk(error_summary_flag, 1'b0);
		rd(12'h004, 32'h00);
		wr(12'h000, 8'h00);
		wr(12'h00c, 8'h00);
	endtask
	// each of the five engine error sources sets its own bit while masked; write 1 keeps, write 0 clears
	task t_err_flags();
		logic [7:0] p;
		for (int i = 0; i < 5; i++) begin
			p = (i == 4) ? 8'h80 : 8'h01 << i;
			uiees_engine_model_i.pulse(6'h00, 5'h01 << i);
			rd(12'h008, {24'h000000, p});
			chk(error_summary_flag, 1'b0);
			wr(12'h008, 8'hff);
			rd(12'h008, {24'h000000, p});
			wr(12'h008, 8'h00);
			rd(12'h008, 32'h00);
		end
	endtask
	task t_summary();
		wr(12'h00c, 8'h04);
		uiees_engine_model_i.pulse(6'h00, 5'h04);
		repeat (3) @(posedge pclk);
		chk(error_summary_flag, 1'b1);
		chk(usb_irq, 1'b0);
		rd(12'h004, 32'h02);
		// a written zero must not clear the read-only summary
		wr(12'h004, 8'h00);
		rd(12'h004, 32'h02);
		wr(12'h000, 8'h02);
		repeat (3) @(posedge pclk);
		chk(usb_irq, 1'b1);
		wr(12'h00c, 8'h00);
		repeat (3) @(posedge pclk);
		chk(error_summary_flag, 1'b0);
		rd(12'h008, 32'h04);
		wr(12'h008, 8'h00);
		wr(12'h000, 8'h00);
	endtask
	task t_status();
		logic [7:0] p;
		for (int i = 0; i < 6; i++) begin
			p = (i == 0) ? 8'h01 : 8'h01 << (i + 1);
			uiees_engine_model_i.pulse(6'h01 << i, 5'h00);
			repeat (3) @(posedge pclk);
			chk(usb_irq, 1'b0);
			rd(12'h004, {24'h000000, p});
			// clear, enable, then raise the event again with its enable set
			wr(12'h004, 8'h00);
			wr(12'h000, p);
			repeat (3) @(posedge pclk);
			chk(usb_irq, 1'b0);
			uiees_engine_model_i.pulse(6'h01 << i, 5'h00);
			repeat (3) @(posedge pclk);
			chk(usb_irq, 1'b1);
			wr(12'h004, 8'h00);
			wr(12'h000, 8'h00);
		end
	endtask
	// timeout only after more than 16 bit times idle; bus activity cancels it
	task t_turnaround();
		uiees_engine_model_i.end_packet();
		// the read samples in the cycle of the 17th bit tick, before its flag lands: still clear
		repeat (31) @(posedge pclk);
		rd(12'h008, 32'h00);
		repeat (8) @(posedge pclk);
		rd(12'h008, 32'h10);
		wr(12'h008, 8'h00);
		uiees_engine_model_i.end_packet();
		uiees_engine_model_i.drive_active(1'b1);
		repeat (60) @(posedge pclk);
		rd(12'h008, 32'h00);
		uiees_engine_model_i.drive_active(1'b0);
	endtask

	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		pstrb = 4'hf;
		errors = 0;
		samples_checked = 0;
		cycles = 0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		t_reset_and_enables();
		t_err_flags();
		t_summary();
		t_status();
		t_turnaround();
		end_sim();
	end
endmodule

// >>> uiees_pkg.sv
package uiees_pkg;

	// one-cycle event pulses from the serial engine for top-level status
	typedef struct packed {
		logic frame_start;
		logic stall;
		logic idle;
		logic trans_done;
		logic bus_activity;
		logic bus_reset;
	} uiees_stat_evt_t;

	// one-cycle error pulses from the serial engine
	typedef struct packed {
		logic bitstuff;
		logic field_size;
		logic data_crc;
		logic token_crc;
		logic packet_id;
	} uiees_err_evt_t;

	// line state used by the turnaround timer
	typedef struct packed {
		logic eop;
		logic bus_active;
	} uiees_link_t;

	typedef enum logic [0:0] {
		TURN_IDLE = 1'b0,
		TURN_WAIT = 1'b1
	} uiees_turn_state_t;

endpackage

// >>> uiees_regs.svh
`ifndef UIEES_REGS_SVH
`define UIEES_REGS_SVH

// register byte offsets on the apb bus
`define UIEES_ADDR_W            12
`define UIEES_OFF_STAT_EN       12'h000
`define UIEES_OFF_STAT_FLAG     12'h004
`define UIEES_OFF_ERR_FLAG      12'h008
`define UIEES_OFF_ERR_EN        12'h00c

// status enable and status flag field positions
`define UIEES_STAT_FRAME_START  6
`define UIEES_STAT_STALL        5
`define UIEES_STAT_IDLE         4
`define UIEES_STAT_TRANS_DONE   3
`define UIEES_STAT_BUS_ACTIVITY 2
`define UIEES_STAT_ERR_SUMMARY  1
`define UIEES_STAT_BUS_RESET    0

// error flag and error enable field positions
`define UIEES_ERR_BITSTUFF      7
`define UIEES_ERR_TURNAROUND    4
`define UIEES_ERR_FIELD_SIZE    3
`define UIEES_ERR_DATA_CRC      2
`define UIEES_ERR_TOKEN_CRC     1
`define UIEES_ERR_PACKET_ID     0

// implemented bits and reset values
`define UIEES_STAT_EN_MASK      8'h7f
`define UIEES_STAT_CLR_MASK     8'h7d
`define UIEES_ERR_MASK          8'h9f
`define UIEES_RESET_VAL         8'h00

// timing: full-speed bit time against the 250 MHz clock
`define UIEES_CLK_PERIOD_PS     4000
`define UIEES_BIT_TIME_PS       83333
`define UIEES_BIT_CYCLES        (`UIEES_BIT_TIME_PS / `UIEES_CLK_PERIOD_PS)
`define UIEES_TURN_BITS         16

`endif

// >>> uiees_sie_model.sv
`timescale 1ns/1ps

module uiees_engine_model (
	input  wire logic                  pclk,
	output uiees_pkg::uiees_stat_evt_t stat_evt,
	output uiees_pkg::uiees_err_evt_t  err_evt,
	output uiees_pkg::uiees_link_t     link
);
	// quiet line, no events pending
	initial begin
		stat_evt = 6'h00;
		err_evt  = 5'h00;
		link     = 2'h0;
	end
	// engine sets flags
	// one-cycle pulses only; the engine never clears a flag itself
	task pulse(input logic [5:0] s, input logic [4:0] e);
		@(posedge pclk);
		stat_evt <= s;
		err_evt  <= e;
		@(posedge pclk);
		stat_evt <= 6'h00;
		err_evt  <= 5'h00;
	endtask
	// end of packet marks the start of the turnaround wait
	task end_packet();
		@(posedge pclk);
		link.eop <= 1'b1;
		@(posedge pclk);
		link.eop <= 1'b0;
	endtask
	task drive_active(input logic a);
		@(posedge pclk);
		link.bus_active <= a;
	endtask
endmodule

// >>> uiees_top.sv
`timescale 1ns/1ps
`include "uiees_regs.svh"

//Operation
// - status enable bits only gate the request, never the flag setting
// - flags still set while their enables are clear, for polling
// - status enable: bit 7 reads 0, bits 6..0 enable sources, reset 0
// - enabled error flags ORed into the error summary flag
// - set error enable lets its flag reach the summary; clear blocks it
// - error flag set in the cycle the error is seen
// - error flag stays set until firmware writes 0; writing 1 keeps it
// - error flag register eight bits, reset 0, bits 6 and 5 read 0
// - idle over 16 bit times after end of packet sets flag bit 4
// - partial-byte data field sets flag bit 3
// - data crc failure sets flag bit 2
// - token rejected on crc5 sets flag bit 1
// - error enable mirrors flag layout, bits 6 and 5 read 0, reset 0
// - error summary is read-only, follows only enabled error flags
module uiees_top #(
	parameter int BIT_CYCLES = `UIEES_BIT_CYCLES,
	parameter int TURN_BITS  = `UIEES_TURN_BITS
) (
	input  wire logic                         pclk,
	input  wire logic                         presetn,
	input  wire logic                         psel,
	input  wire logic                         penable,
	input  wire logic                         pwrite,
	input  wire logic [`UIEES_ADDR_W-1:0]     paddr,
	input  wire logic [31:0]                  pwdata,
	input  wire logic [3:0]                   pstrb,
	output logic      [31:0]                  prdata,
	output logic                              pready,
	output logic                              pslverr,
	input  wire uiees_pkg::uiees_stat_evt_t   stat_evt,
	input  wire uiees_pkg::uiees_err_evt_t    err_evt,
	input  wire uiees_pkg::uiees_link_t       link,
	output logic                              usb_irq,
	output logic                              error_summary_flag
);

	localparam int DIV_W = (BIT_CYCLES > 1) ? $clog2(BIT_CYCLES) : 1;
	localparam int BIT_W = $clog2(TURN_BITS + 1);

	// refuse settings that the counters cannot serve
	if (BIT_CYCLES < 1) begin : g_bad_div
		$error("bit time must be at least one clock cycle");
	end
	if (TURN_BITS < 1) begin : g_bad_turn
		$error("turnaround limit must be at least one bit time");
	end

	// register contents
	logic [7:0]                         status_irq_enable_reg;
	logic [7:0]                         status_irq_flag_reg;
	logic [7:0]                         error_flag_reg;
	logic [7:0]                         error_enable_reg;
	logic [7:0]                         next_status_irq_enable_reg;
	logic [7:0]                         next_status_irq_flag_reg;
	logic [7:0]                         next_error_flag_reg;
	logic [7:0]                         next_error_enable_reg;
	logic                               next_usb_irq;
	logic                               next_error_summary_flag;

	// bus side state
	logic [31:0]                        next_prdata;
	logic                               next_pready;
	logic                               next_pslverr;

	// turnaround timer state
	uiees_pkg::uiees_turn_state_t       turn_state;
	uiees_pkg::uiees_turn_state_t       next_turn_state;
	logic [DIV_W-1:0]                   div_cnt;
	logic [DIV_W-1:0]                   next_div_cnt;
	logic [BIT_W-1:0]                   bit_cnt;
	logic [BIT_W-1:0]                   next_bit_cnt;
	logic                               turn_timeout;

	// decoded bus strobes
	logic                               acc_first;
	logic                               acc_done;
	logic                               wr_lane0;
	logic [7:0]                         wr_byte;
	logic [7:0]                         err_set;
	logic [7:0]                         stat_set;
	logic [7:0]                         err_clr;
	logic [7:0]                         stat_clr;
	logic [7:0]                         stat_view;

	// true when the offset names one of the four registers
	function automatic logic addr_hit(input logic [`UIEES_ADDR_W-1:0] a);
		addr_hit = (a == `UIEES_OFF_STAT_EN) || (a == `UIEES_OFF_STAT_FLAG) ||
			(a == `UIEES_OFF_ERR_FLAG) || (a == `UIEES_OFF_ERR_EN);
	endfunction

	// write strobe for one register, taken only at the completing edge
	function automatic logic reg_write(
		input logic                         done,
		input logic                         lane,
		input logic [`UIEES_ADDR_W-1:0]     a,
		input logic [`UIEES_ADDR_W-1:0]     off
	);
		reg_write = done && lane && (a == off);
	endfunction

	// first access cycle raises pready next; the completing edge is the next one
	assign acc_first = psel && penable && !pready;
	assign acc_done  = psel && penable && pready;
	// register data lives in byte lane 0; other lanes are ignored
	assign wr_lane0  = pwrite && pstrb[0];
	assign wr_byte   = pwdata[7:0];

	// flag view for reads: the summary bit is whatever the error side says
	// summary read-only
	always_comb begin
		stat_view = status_irq_flag_reg & `UIEES_STAT_CLR_MASK;
		stat_view[`UIEES_STAT_ERR_SUMMARY] = error_summary_flag;
	end

	// bus answer: one wait state, then pready with data or an error for holes
	always_comb begin
		next_pready  = acc_first;
		next_pslverr = acc_first && !addr_hit(paddr);
		next_prdata  = prdata;
		if (acc_first && !pwrite) begin
			next_prdata = 32'h0000_0000;
			unique case (paddr)
				`UIEES_OFF_STAT_EN:   next_prdata[7:0] = status_irq_enable_reg;
				`UIEES_OFF_STAT_FLAG: next_prdata[7:0] = stat_view;
				// bits 6 and 5 read zero
				`UIEES_OFF_ERR_FLAG:  next_prdata[7:0] = error_flag_reg;
				`UIEES_OFF_ERR_EN:    next_prdata[7:0] = error_enable_reg;
				default:              next_prdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= next_pready;
			pslverr <= next_pslverr;
			prdata  <= next_prdata;
		end
	end

	// turnaround timer: bit-time enable divider restarts at each end of packet seen in TURN_IDLE,
	// so the first bit boundary falls exactly one bit time after it
	always_comb begin
		next_turn_state = turn_state;
		next_div_cnt    = div_cnt;
		next_bit_cnt    = bit_cnt;
		turn_timeout    = 1'b0;
		unique case (turn_state)
			uiees_pkg::TURN_IDLE: begin
				if (link.eop) begin
					next_turn_state = uiees_pkg::TURN_WAIT;
					next_div_cnt    = '0;
					next_bit_cnt    = '0;
				end
			end
			uiees_pkg::TURN_WAIT: begin
				if (link.bus_active) begin
					// the other side answered in time
					next_turn_state = uiees_pkg::TURN_IDLE;
				end else if (div_cnt == DIV_W'(BIT_CYCLES - 1)) begin
					next_div_cnt = '0;
					// more than the limit means the tick after the last
					if (bit_cnt == BIT_W'(TURN_BITS)) begin
						turn_timeout    = 1'b1;
						next_turn_state = uiees_pkg::TURN_IDLE;
					end else begin
						next_bit_cnt = bit_cnt + BIT_W'(1);
					end
				end else begin
					next_div_cnt = div_cnt + DIV_W'(1);
				end
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			turn_state <= uiees_pkg::TURN_IDLE;
			div_cnt    <= '0;
			bit_cnt    <= '0;
		end else begin
			turn_state <= next_turn_state;
			div_cnt    <= next_div_cnt;
			bit_cnt    <= next_bit_cnt;
		end
	end

	// error sources, mapped onto their flag positions
	always_comb begin
		err_set = 8'h00;
		err_set[`UIEES_ERR_BITSTUFF]   = err_evt.bitstuff;
		err_set[`UIEES_ERR_TURNAROUND] = turn_timeout;
		err_set[`UIEES_ERR_FIELD_SIZE] = err_evt.field_size;
		err_set[`UIEES_ERR_DATA_CRC]   = err_evt.data_crc;
		err_set[`UIEES_ERR_TOKEN_CRC]  = err_evt.token_crc;
		err_set[`UIEES_ERR_PACKET_ID]  = err_evt.packet_id;
	end

	// status sources; the summary position is never a stored flag
	always_comb begin
		stat_set = 8'h00;
		stat_set[`UIEES_STAT_FRAME_START]  = stat_evt.frame_start;
		stat_set[`UIEES_STAT_STALL]        = stat_evt.stall;
		stat_set[`UIEES_STAT_IDLE]         = stat_evt.idle;
		stat_set[`UIEES_STAT_TRANS_DONE]   = stat_evt.trans_done;
		stat_set[`UIEES_STAT_BUS_ACTIVITY] = stat_evt.bus_activity;
		stat_set[`UIEES_STAT_BUS_RESET]    = stat_evt.bus_reset;
	end

	// a written 0 clears, a written 1 leaves the flag alone
	always_comb begin
		err_clr  = 8'h00;
		stat_clr = 8'h00;
		if (reg_write(acc_done, wr_lane0, paddr, `UIEES_OFF_ERR_FLAG)) begin
			err_clr = ~wr_byte & `UIEES_ERR_MASK;
		end
		if (reg_write(acc_done, wr_lane0, paddr, `UIEES_OFF_STAT_FLAG)) begin
			stat_clr = ~wr_byte & `UIEES_STAT_CLR_MASK;
		end
	end

	// register next values; set terms come last so a same-cycle event wins
	always_comb begin
		next_status_irq_enable_reg = status_irq_enable_reg;
		next_error_enable_reg      = error_enable_reg;
		if (reg_write(acc_done, wr_lane0, paddr, `UIEES_OFF_STAT_EN)) begin
			next_status_irq_enable_reg = wr_byte & `UIEES_STAT_EN_MASK;
		end
		if (reg_write(acc_done, wr_lane0, paddr, `UIEES_OFF_ERR_EN)) begin
			next_error_enable_reg = wr_byte & `UIEES_ERR_MASK;
		end
		next_error_flag_reg = ((error_flag_reg & ~err_clr) | err_set) & `UIEES_ERR_MASK;
		// enables play no part in setting
		next_status_irq_flag_reg =
			((status_irq_flag_reg & ~stat_clr) | stat_set) & `UIEES_STAT_CLR_MASK;
		next_error_summary_flag = |(error_flag_reg & error_enable_reg);
		next_usb_irq = |(stat_view & status_irq_enable_reg);
	end

	// registers hold zero from reset; the summary lags its flags by a cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_irq_enable_reg <= `UIEES_RESET_VAL;
			status_irq_flag_reg   <= `UIEES_RESET_VAL;
			error_flag_reg        <= `UIEES_RESET_VAL;
			error_enable_reg      <= `UIEES_RESET_VAL;
			error_summary_flag    <= 1'b0;
			usb_irq               <= 1'b0;
		end else begin
			status_irq_enable_reg <= next_status_irq_enable_reg;
			status_irq_flag_reg   <= next_status_irq_flag_reg;
			error_flag_reg        <= next_error_flag_reg;
			error_enable_reg      <= next_error_enable_reg;
			error_summary_flag    <= next_error_summary_flag;
			usb_irq               <= next_usb_irq;
		end
	end

endmodule

// >>> uiees_top_asserts.sv
`timescale 1ns/1ps
`include "uiees_regs.svh"

module uiees_chk (
	input wire logic                       pclk,
	input wire logic                       presetn,
	input wire logic                       psel,
	input wire logic                       penable,
	input wire logic                       pwrite,
	input wire logic [`UIEES_ADDR_W-1:0]   paddr,
	input wire logic [31:0]                pwdata,
	input wire logic [3:0]                 pstrb,
	input wire logic [31:0]                prdata,
	input wire logic                       pready,
	input wire logic                       pslverr,
	input wire uiees_pkg::uiees_stat_evt_t stat_evt,
	input wire uiees_pkg::uiees_err_evt_t  err_evt,
	input wire logic                       usb_irq,
	input wire logic                       error_summary_flag
);
	logic [7:0] stat_en, err_en, next_stat_en, next_err_en;
	logic       wr;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// shadow enables rebuilt from completed writes, since the checker cannot see inside
	assign wr = psel & penable & pready & pwrite & pstrb[0];
	always_comb begin
		next_stat_en = (wr && paddr == `UIEES_OFF_STAT_EN) ? pwdata[7:0] & 8'h7f : stat_en;
		next_err_en  = (wr && paddr == `UIEES_OFF_ERR_EN) ? pwdata[7:0] & 8'h9f : err_en;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_en <= 8'h00;
			err_en  <= 8'h00;
		end else begin
			stat_en <= next_stat_en;
			err_en  <= next_err_en;
		end
	end
	// bus timing and read fields
	a_one_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
		else $error("pready not in second access cycle");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready held too long");
	a_unmapped_err: assert property (pready && paddr[1:0] == 2'h0 |-> pslverr == (paddr > 12'h00c))
		else $error("pslverr wrong for address");
	a_read_fields: assert property (pready && !pwrite |-> prdata[31:8] == 24'h000000 && !(paddr == 12'h000 && prdata[7]) && !(paddr[3] && prdata[6:5] != 2'h0))
		else $error("unimplemented read bit set");
	// enabled engine events reach the outputs; with all enables clear, neither output rises
	a_err_summary: assert property ((|(err_evt & {err_en[7], err_en[3:0]})) && !wr |-> ##2 error_summary_flag)
		else $error("enabled error did not raise summary");
	a_summary_masked: assert property (err_en == 8'h00 [*2] |-> !error_summary_flag)
		else $error("summary raised with all error enables clear");
	a_stat_irq: assert property ((|(stat_evt & {stat_en[6:2], stat_en[0]})) && !wr |-> ##2 usb_irq)
		else $error("enabled status event did not raise request");
	a_irq_masked: assert property (stat_en == 8'h00 [*2] |-> !usb_irq)
		else $error("request raised with all status enables clear");
endmodule

bind uiees_top uiees_chk uiees_chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .stat_evt(stat_evt),
	.err_evt(err_evt), .usb_irq(usb_irq), .error_summary_flag(error_summary_flag));
